// File: design/isp_pkg.sv
// Purpose: Shared constants and types for the serial ISP programmer
// Assumes: mclk at 20 MHz; target oscillator driven from mclk / 2
// Notes: Register offsets are byte addresses on the local port
package isp_pkg;

  // Clock and timing figures
  localparam int unsigned MCLK_HZ = 20_000_000; // Controller clock
  localparam int unsigned OSC_DIV = 2; // mclk cycles per osc period
  localparam int unsigned SCK_PER_OSC = 16; // Osc periods per sck period
  localparam int unsigned QUIET_OSC = 64; // Osc clocks of low sck
  localparam int unsigned ERASE_TIME_MS = 500; // Chip erase time
  localparam int unsigned WRITE_OSC = 64; // Write time, osc part
  localparam int unsigned WRITE_TIME_US = 400; // Write time, fixed part

  // Derived cycle counts
  localparam int unsigned SCK_HALF_CYC = OSC_DIV * SCK_PER_OSC / 2;
  localparam logic [4:0] SCK_HALF_LAST = 5'(SCK_HALF_CYC - 1);
  localparam logic [23:0] QUIET_CYC = 24'(QUIET_OSC * OSC_DIV);
  localparam int unsigned ERASE_WAIT_DEF = (MCLK_HZ / 1000) * ERASE_TIME_MS;
  localparam int unsigned WRITE_WAIT_DEF =
    WRITE_OSC * OSC_DIV + (MCLK_HZ / 1_000_000) * WRITE_TIME_US;

  // Local register offsets
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_INSTR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;

  // Status bit positions
  localparam int unsigned STB_BUSY = 0;
  localparam int unsigned STB_ENABLED = 1;
  localparam int unsigned STB_NEED = 2;
  localparam int unsigned STB_RXFULL = 3;
  localparam int unsigned STB_REFUSED = 4;
  localparam int unsigned STB_QUIET = 5;
  localparam int unsigned STB_LVL = 8;

  // Instruction codes
  localparam logic [7:0] OP_PREFIX = 8'hAC;
  localparam logic [7:0] OP_ENABLE2 = 8'h53;
  localparam logic [7:0] OP_ACK = 8'h69;
  localparam logic [2:0] ERASE_SEL = 3'h4;
  localparam logic [5:0] LOCK_SEL = 6'h38;
  localparam logic [7:0] OP_WR_BYTE = 8'h40;
  localparam logic [7:0] OP_RD_PAGE = 8'h30;
  localparam logic [7:0] OP_WR_PAGE = 8'h50;
  localparam logic [7:0] FILL_BYTE = 8'h00;

  // Byte counts
  localparam logic [8:0] LAST_FOUR = 9'h003;
  localparam logic [8:0] LAST_HDR = 9'h001;
  localparam logic [8:0] LAST_PAGE = 9'h101; // Two header, 256 data

  // Controller states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_QUIET = 3'b001,
    ST_SHIFT = 3'b010,
    ST_NEED = 3'b011,
    ST_HOLD = 3'b100,
    ST_WAIT = 3'b101
  } isp_state_type;

  // Transfer shapes
  typedef enum logic [1:0] {
    MD_FOUR = 2'b00,
    MD_PREAD = 2'b01,
    MD_PWRITE = 2'b10
  } isp_mode_type;

  // Local bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } isp_bus_type;

  // Pins driven toward the target
  typedef struct packed {
    logic rst_hold;
    logic sck;
    logic mosi;
    logic osc;
  } isp_pin_type;

endpackage

// File: design/isp_host.sv
// Purpose: Programmer that drives a target flash over the serial ISP link
// Assumes: Target oscillator input is fed from pins.osc
// Notes: Software writes a 4-byte word to INSTR; page data via DATA
// Notes on behaviour
// R1: Enable is AC 53 xx xx, reset held
// R2: Fourth enable byte must read back 69
// R3: AC with 100x xxxx erases whole array
// R4: Opcode 20 reads one byte, byte 4
// R5: Opcode 40 writes byte 4 to address
// R6: AC with 1110 00xx writes lock level
// R7: Lock field 00..11 maps modes 1..4
// R8: Lock modes applied in ascending order only
// R9: Opcode 24 returns lock bits in byte 4
// R10: Opcode 30 streams 256 page bytes out
// R11: Opcode 50 takes 256 page bytes in
// R12: Page data runs offset 0 to 255
// R13: After header every byte is page data
// R14: After 256 bytes decode resumes
// R15: Sck low 64 osc clocks after reset
// R16: Reset held high, never pulsed
// R17: Sck at most osc over sixteen
// R18: Data in on rising, out after falling
// R19: Allow 500 ms after chip erase
// R20: Allow 64 osc plus 400 us per write
// R21: Target rejects all until enabled
// R22: Erase sets every byte to FF
// R23: Busy read returns inverted top bit
// R24: Msb first, four bytes per instruction
// R25: Unknown opcodes are ignored by target
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
module isp_host #(
  parameter int unsigned ERASE_WAIT_CYC = isp_pkg::ERASE_WAIT_DEF,
  parameter int unsigned WRITE_WAIT_CYC = isp_pkg::WRITE_WAIT_DEF
) (
  input wire logic mclk,
  input wire logic rst_b,
  input isp_pkg::isp_bus_type bus,
  output logic [31:0] bus_rdata,
  output isp_pkg::isp_pin_type pins,
  input wire logic isp_miso
);
  import isp_pkg::*;

  // Whole controller state
  typedef struct packed {
    isp_state_type st;
    isp_mode_type mode;
    isp_pin_type pin;
    logic miso_s1; // First sync stage
    logic miso_s2; // Second sync stage
    logic [4:0] div; // Half-period countdown
    logic [2:0] bitn; // Bit within byte
    logic [7:0] sh_tx; // Outgoing byte
    logic [7:0] sh_rx; // Incoming byte
    logic [31:0] instr; // Remaining instruction bytes
    logic [8:0] bytei; // Byte index in transfer
    logic [23:0] timer; // Wait countdown
    logic [23:0] post; // Wait after transfer, 0 for none
    logic is_en; // Transfer is the enable
    logic is_lock; // Transfer writes lock bits
    logic [1:0] lock_req; // Requested lock field
    logic [1:0] lvl; // Lock field applied so far
    logic enabled; // Target acknowledged enable
    logic refused; // Sticky refused request
    logic rx_full; // Received byte waiting
    logic [7:0] rx; // Last received byte
    logic [31:0] rdata; // Read data register
  } isp_reg_type;

  isp_reg_type s; // Current state
  isp_reg_type next_s; // Next state

  // Request decode
  logic wr_ctl; // Control write
  logic wr_ins; // Instruction write
  logic wr_dat; // Data write
  logic wr_sts; // Status write
  logic rd_dat; // Data read
  logic [7:0] w_op; // First byte of written word
  logic [7:0] w_sel; // Second byte of written word
  logic w_en; // Word is the enable
  logic w_erase; // Word is chip erase
  logic w_lock; // Word is lock write
  logic lock_ok; // Lock request in order
  logic start_ok; // Instruction may start
  logic [31:0] status; // Status word

  assign wr_ctl = bus.wr && (bus.addr == REG_CONTROL);
  assign wr_ins = bus.wr && (bus.addr == REG_INSTR);
  assign wr_dat = bus.wr && (bus.addr == REG_DATA);
  assign wr_sts = bus.wr && (bus.addr == REG_STATUS);
  assign rd_dat = bus.rd && (bus.addr == REG_DATA);
  assign w_op = bus.wdata[31:24];
  assign w_sel = bus.wdata[23:16];
  assign w_en = (w_op == OP_PREFIX) && (w_sel == OP_ENABLE2); // [R1]
  assign w_erase = (w_op == OP_PREFIX) && (w_sel[7:5] == ERASE_SEL); // [R3]
  assign w_lock = (w_op == OP_PREFIX) && (w_sel[7:2] == LOCK_SEL); // [R6]
  // Field 00..11 is mode 1..4; any mode up to the next one above the current may follow
  assign lock_ok = (w_sel[1:0] <= s.lvl) ||
                   (w_sel[1:0] == 2'(s.lvl + 2'h1)); // [R7] [R8]
  // Nothing but the enable goes out before it was acknowledged
  assign start_ok = (s.st == ST_IDLE) && s.pin.rst_hold &&
                    (s.enabled || w_en) && (!w_lock || lock_ok); // [R21]

  // Status word
  always_comb begin
    status = '0;
    status[STB_BUSY] = (s.st != ST_IDLE);
    status[STB_ENABLED] = s.enabled;
    status[STB_NEED] = (s.st == ST_NEED);
    status[STB_RXFULL] = s.rx_full;
    status[STB_REFUSED] = s.refused;
    status[STB_QUIET] = (s.st == ST_QUIET);
    status[STB_LVL +: 2] = s.lvl;
  end

  // Next-state logic
  always_comb begin
    next_s = s;
    next_s.pin.osc = ~s.pin.osc; // Target clock, mclk over two
    next_s.miso_s1 = isp_miso;
    next_s.miso_s2 = s.miso_s1;
    // Read mux, data valid only in the cycle after the strobe
    next_s.rdata = '0;
    if (bus.rd) begin
      unique case (bus.addr)
        REG_CONTROL: next_s.rdata = {31'h0, s.pin.rst_hold};
        REG_DATA: next_s.rdata = {24'h0, s.rx};
        REG_STATUS: next_s.rdata = status;
        default: next_s.rdata = '0; // Unmapped reads zero
      endcase
    end
    // Software clears, hardware sets below and wins
    if (wr_sts && bus.wdata[STB_REFUSED]) begin
      next_s.refused = 1'b0;
    end
    if (rd_dat) begin
      next_s.rx_full = 1'b0;
    end
    if (wr_ins && !start_ok) begin
      next_s.refused = 1'b1;
    end
    unique case (s.st)
      // Idle, accept a new instruction word
      ST_IDLE: begin
        if (wr_ins && start_ok) begin
          next_s.st = ST_SHIFT;
          next_s.sh_tx = w_op;
          next_s.pin.mosi = w_op[7]; // [R24]
          next_s.instr = {bus.wdata[23:0], 8'h00};
          next_s.bytei = '0;
          next_s.bitn = '0;
          next_s.div = SCK_HALF_LAST;
          next_s.is_en = w_en;
          next_s.is_lock = w_lock;
          next_s.lock_req = w_sel[1:0];
          if (w_op == OP_RD_PAGE) begin
            next_s.mode = MD_PREAD; // [R10]
          end else if (w_op == OP_WR_PAGE) begin
            next_s.mode = MD_PWRITE; // [R11]
          end else begin
            next_s.mode = MD_FOUR; // [R4] [R9]
          end
          if (w_erase) begin
            next_s.post = 24'(ERASE_WAIT_CYC); // [R19]
          end else if (w_op == OP_WR_BYTE || w_op == OP_WR_PAGE || w_lock) begin
            next_s.post = 24'(WRITE_WAIT_CYC); // [R5] [R20]
          end else begin
            next_s.post = '0;
          end
        end
      end
      // Sck held low after reset raised
      ST_QUIET: begin
        if (s.timer == '0) begin
          next_s.st = ST_IDLE; // [R15]
        end else begin
          next_s.timer = s.timer - 24'h1;
        end
      end
      // Bit engine, each half period 8 osc periods long
      ST_SHIFT: begin
        if (s.div != '0) begin
          next_s.div = s.div - 5'h1; // [R17]
        end else begin
          next_s.div = SCK_HALF_LAST;
          if (!s.pin.sck) begin
            // Sample just before the rising edge
            next_s.pin.sck = 1'b1;
            next_s.sh_rx = {s.sh_rx[6:0], s.miso_s2}; // [R18]
          end else begin
            // Falling edge, then present the next bit
            next_s.pin.sck = 1'b0;
            if (s.bitn != 3'h7) begin
              next_s.bitn = s.bitn + 3'h1;
              next_s.sh_tx = {s.sh_tx[6:0], 1'b0};
              next_s.pin.mosi = s.sh_tx[6]; // [R18] [R24]
            end else begin
              next_s.bitn = '0;
              if (s.bytei == '0 ||
                  (s.mode == MD_FOUR && s.bytei != LAST_FOUR)) begin
                // Next byte of the instruction word
                next_s.sh_tx = s.instr[31:24];
                next_s.pin.mosi = s.instr[31];
                next_s.instr = {s.instr[23:0], 8'h00};
                next_s.bytei = s.bytei + 9'h1; // [R24]
              end else begin
                unique case (s.mode)
                  MD_FOUR: begin
                    next_s.rx = s.sh_rx;
                    next_s.rx_full = 1'b1;
                    if (s.is_en && s.sh_rx == OP_ACK) begin
                      next_s.enabled = 1'b1; // [R2]
                    end
                    if (s.is_lock && s.lock_req > s.lvl) begin
                      next_s.lvl = s.lock_req; // [R8]
                    end
                    if (s.post != '0) begin
                      next_s.st = ST_WAIT;
                      next_s.timer = s.post - 24'h1;
                    end else begin
                      next_s.st = ST_IDLE;
                    end
                  end
                  MD_PREAD: begin
                    if (s.bytei == LAST_HDR) begin
                      // Header done, clock out fill while reading
                      next_s.bytei = s.bytei + 9'h1; // [R13]
                      next_s.sh_tx = FILL_BYTE;
                      next_s.pin.mosi = FILL_BYTE[7];
                    end else begin
                      next_s.rx = s.sh_rx;
                      next_s.rx_full = 1'b1;
                      next_s.st = ST_HOLD;
                    end
                  end
                  MD_PWRITE: begin
                    if (s.bytei == LAST_PAGE) begin
                      next_s.st = ST_WAIT; // [R14]
                      next_s.timer = s.post - 24'h1;
                    end else begin
                      next_s.bytei = s.bytei + 9'h1; // [R12] [R13]
                      next_s.st = ST_NEED;
                    end
                  end
                  default: next_s.st = ST_IDLE; // Illegal mode code
                endcase
              end
            end
          end
        end
      end
      // Page write stalls until software gives the next byte
      ST_NEED: begin
        if (wr_dat) begin
          next_s.sh_tx = bus.wdata[7:0];
          next_s.pin.mosi = bus.wdata[7];
          next_s.div = SCK_HALF_LAST;
          next_s.st = ST_SHIFT; // [R11]
        end
      end
      // Page read stalls until software takes the byte
      ST_HOLD: begin
        if (!s.rx_full) begin
          if (s.bytei == LAST_PAGE) begin
            next_s.st = ST_IDLE; // [R14]
          end else begin
            next_s.bytei = s.bytei + 9'h1; // [R12]
            next_s.sh_tx = FILL_BYTE;
            next_s.pin.mosi = FILL_BYTE[7];
            next_s.div = SCK_HALF_LAST;
            next_s.st = ST_SHIFT;
          end
        end
      end
      // Self-timed erase or write still running
      ST_WAIT: begin
        if (s.timer == '0) begin
          next_s.st = ST_IDLE; // [R19] [R20]
        end else begin
          next_s.timer = s.timer - 24'h1;
        end
      end
      default: next_s.st = ST_IDLE; // Illegal state code
    endcase
    // Session end overrides any transfer; a start write inside a session is ignored
    if (wr_ctl) begin
      if (bus.wdata[0] && !s.pin.rst_hold) begin
        next_s.pin.rst_hold = 1'b1; // [R16]
        next_s.pin.sck = 1'b0;
        next_s.st = ST_QUIET;
        next_s.timer = QUIET_CYC - 24'h1; // [R15]
      end else if (!bus.wdata[0]) begin
        next_s.pin.rst_hold = 1'b0;
        next_s.pin.sck = 1'b0;
        next_s.pin.mosi = 1'b0;
        next_s.enabled = 1'b0;
        next_s.lvl = '0;
        next_s.st = ST_IDLE;
      end
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pins = s.pin;
  assign bus_rdata = s.rdata;

endmodule // isp_host

// File: verif/isp_host_monitor.sv
// Purpose: Checker for the programmer's link pins and local port
// Assumes: Bound to every isp_host instance
// Notes: Helper counters carry the holds too long for repetition
`timescale 1ns/1ps
module isp_host_monitor (
  input wire logic mclk,
  input wire logic rst_b,
  input isp_pkg::isp_bus_type bus,
  input wire logic [31:0] bus_rdata,
  input isp_pkg::isp_pin_type pins,
  input wire logic isp_miso
);
  import isp_pkg::*;
  logic [7:0] qc; // Cycles since target reset pin rose
  logic [2:0] rc; // Rising shift edges modulo one byte
  logic sck_q; // Last shift clock level
  logic ctl_on; // Session start asked this cycle
  logic ctl_off; // Session end asked this cycle
  assign ctl_on = bus.wr && (bus.addr == REG_CONTROL) && bus.wdata[0];
  assign ctl_off = bus.wr && (bus.addr == REG_CONTROL) && !bus.wdata[0];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Count quiet cycles and shift edges within a session
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      qc <= 8'h00;
      rc <= 3'h0;
      sck_q <= 1'b0;
    end else begin
      sck_q <= pins.sck;
      if (!pins.rst_hold) begin
        qc <= 8'h00;
        rc <= 3'h0;
      end else begin
        if (qc != 8'hFF) qc <= qc + 8'h01;
        if (pins.sck && !sck_q) rc <= rc + 3'h1;
      end
    end
  end
  // Fifteen further samples of an unchanged shift clock
  sequence s_half;
    (!pins.rst_hold || $stable(pins.sck))[*8] ##1
    (!pins.rst_hold || $stable(pins.sck))[*7];
  endsequence
  // Shift clock parked low one cycle past a half period
  sequence s_stall;
    $fell(pins.sck) ##1 (!pins.sck)[*8] ##1 (!pins.sck)[*8];
  endsequence
  osc_toggle_a: assert property ($past(rst_b) |->
    pins.osc != $past(pins.osc)) else $error("osc pin stuck");
  sck_half_a: assert property ($changed(pins.sck) |=> s_half)
    else $error("shift clock half period short");
  quiet_low_a: assert property ($rose(pins.sck) |-> qc >= 8'h80)
    else $error("shift clock rose too soon");
  sck_idle_a: assert property (!pins.rst_hold &&
    !$past(pins.rst_hold) |-> !pins.sck) else $error("sck outside session");
  mosi_hold_a: assert property ($rose(pins.sck) |->
    (!pins.rst_hold || $stable(pins.mosi))[*5]) else $error("mosi moved");
  mosi_move_a: assert property ($changed(pins.mosi) |->
    !pins.sck || !pins.rst_hold) else $error("mosi moved while sck high");
  whole_bytes_a: assert property (s_stall |-> rc == 3'h0)
    else $error("stall inside a byte");
  hold_rise_a: assert property ($rose(pins.rst_hold) |->
    $past(ctl_on)) else $error("reset pin rose unasked");
  hold_fall_a: assert property ($fell(pins.rst_hold) |->
    $past(ctl_off)) else $error("reset pin pulsed");
  rdata_idle_a: assert property (!$past(bus.rd) |-> bus_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule // isp_host_monitor
bind isp_host isp_host_monitor u_mon (.mclk(mclk), .rst_b(rst_b),
  .bus(bus), .bus_rdata(bus_rdata), .pins(pins), .isp_miso(isp_miso));

// File: verif/isp_target.sv
// Purpose: Behavioural flash target on the serial programming link
// Assumes: 8K code array, lock bits kept across sessions
// Notes: Undriven output bytes carry the inverse of the last input
`timescale 1ns/1ps
module isp_target (
  input wire logic rst_hold,
  input wire logic sck,
  input wire logic mosi,
  output logic miso
);
  logic [7:0] mem [0:8191]; // Code array
  logic [7:0] sh, op, hi, lo, os; // Shifter, header bytes, output byte
  logic [2:0] bc, lb; // Bit count, programmed lock bits
  logic [8:0] bi; // Byte index in instruction
  logic en, pg; // Enabled, page transfer
  logic [12:0] wa; // Address of the last opcode 40 byte write
  logic poll; // Addressed byte still being written
  time wt; // Start of the last self-timed byte write
  localparam time POLL_NS = 900; // Model's self-timed write length
  initial begin
    miso = 1'b0;
    lb = 3'h0;
    os = 8'h5A;
    wa = 13'h0000;
    wt = 64'h0;
  end
  // Take one bit per rising edge, act per whole byte
  always @(posedge sck or negedge rst_hold) begin
    if (!rst_hold) begin
      bc = 3'h0;
      bi = 9'h000;
      en = 1'b0;
    end else begin
      sh = {sh[6:0], mosi};
      bc = bc + 3'h1;
      if (bc == 3'h0) begin
        os = ~sh;
        if (bi == 9'h000) op = sh;
        if (bi == 9'h001) hi = sh;
        if (bi == 9'h002) lo = sh;
        pg = en && (op == 8'h30 || op == 8'h50);
        // Page data from offset 0 upward
        if (pg && op == 8'h30 && bi != 9'h000 && bi != 9'h101)
          os = mem[{hi[4:0], 8'(bi - 9'h001)}];
        if (pg && op == 8'h50 && bi >= 9'h002)
          mem[{hi[4:0], 8'(bi - 9'h002)}] = sh;
        if (!pg && bi == 9'h002) begin
          if (op == 8'hAC && hi == 8'h53) os = 8'h69;
          // Byte still being written reads with its top bit inverted
          poll = (($time - wt) < POLL_NS) && (wa == {hi[4:0], sh});
          if (en && op == 8'h20)
            os = mem[{hi[4:0], sh}] ^ {poll, 7'h00};
          if (en && op == 8'h24) os = {3'h0, lb, 2'h0};
        end
        if (!pg && bi == 9'h003) begin
          if (op == 8'hAC && hi == 8'h53) en = 1'b1;
          // Unknown first bytes fall through untouched
          if (en && op == 8'h40) begin
            mem[{hi[4:0], lo}] = sh;
            wa = {hi[4:0], lo};
            wt = $time;
          end
          if (en && op == 8'hAC && hi[7:5] == 3'h4)
            foreach (mem[i]) mem[i] = 8'hFF;
          if (en && op == 8'hAC && hi[7:2] == 6'h38)
            lb = lb | ((3'h1 << hi[1:0]) - 3'h1);
        end
        // Back to decoding after the last byte
        bi = (bi == (pg ? 9'h101 : 9'h003)) ? 9'h000 : bi + 9'h001;
      end
    end
  end
  // New output bit after each falling edge
  always @(negedge sck) begin
    miso = os[7];
    os = {os[6:0], ~os[0]};
  end
  // Released line shows no stale level
  always @(negedge rst_hold) miso = ~miso;
endmodule // isp_target

// File: verif/isp_host_tb.sv
// Purpose: Self-checking bench for the serial ISP programmer
// Assumes: Short erase and write waits via parameters
// Notes: Page read is cut short by ending the session
`timescale 1ns/1ps
module isp_host_tb;
  import isp_pkg::*;
  logic mclk, rst_b, isp_miso; // Clock, reset, target data
  isp_bus_type bus; // Local port request
  logic [31:0] bus_rdata, rd_v; // Read data, last read
  isp_pin_type pins; // Pins to target
  int num_errors, n_checks; // Tallies
  isp_host #(.ERASE_WAIT_CYC(20), .WRITE_WAIT_CYC(20)) DUT (.mclk(mclk),
    .rst_b(rst_b), .bus(bus), .bus_rdata(bus_rdata), .pins(pins),
    .isp_miso(isp_miso));
  isp_target u_tgt (.rst_hold(pins.rst_hold), .sck(pins.sck),
    .mosi(pins.mosi), .miso(isp_miso));
  // Compare and tally
  task automatic check(input string what, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask
  // One-cycle read strobe, data in the next cycle
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 rd_v = bus_rdata;
  endtask
  // Poll a status bit, bounded
  task automatic wait_st(input int b, input logic v);
    for (int i = 0; i < 3000; i++) begin
      rd(REG_STATUS);
      if (rd_v[b] === v) return;
    end
    check("status wait", 32'(v), 32'(rd_v[b]));
  endtask
  task automatic instr(input logic [31:0] w);
    wr(REG_INSTR, w);
    wait_st(STB_BUSY, 1'b0);
  endtask
  task automatic rbyte(input logic [12:0] a, input logic [7:0] e);
    instr({8'h20, 3'h0, a, 8'h00});
    rd(REG_DATA);
    check("code byte", {24'h0, e}, rd_v);
  endtask
  // Reset values, unmapped read, session start
  task automatic t_session();
    rd(REG_STATUS);
    check("status at reset", 32'h0, rd_v);
    rd(8'h10);
    check("unmapped read", 32'h0, rd_v);
    wr(REG_CONTROL, 32'h1);
    rd(REG_STATUS);
    check("status in quiet", 32'h21, rd_v);
    check("reset pin", 32'h1, 32'(pins.rst_hold));
    wait_st(STB_BUSY, 1'b0);
    $display("test session done");
  endtask
  // Refusal before enable, then enable with acknowledge
  task automatic t_enable();
    wr(REG_INSTR, 32'h2000_0000);
    rd(REG_STATUS);
    check("refused before enable", 32'h10, rd_v);
    wr(REG_STATUS, 32'h10);
    instr(32'hAC53_0000);
    rd(REG_STATUS);
    check("enabled status", 32'h0A, rd_v);
    rd(REG_DATA);
    check("enable echo", 32'h69, rd_v);
    $display("test enable done");
  endtask
  // Erase, byte write and read, unknown opcode
  task automatic t_bytes();
    instr(32'hAC80_0000);
    rbyte(13'h1FFF, 8'hFF);
    instr(32'h4001_23A5);
    rbyte(13'h0123, 8'hA5);
    instr(32'h7701_235A);
    rbyte(13'h0123, 8'hA5);
    $display("test bytes done");
  endtask
  // Full page write, partial page read, abort
  task automatic t_page();
    wr(REG_INSTR, 32'h5003_0000);
    for (int i = 0; i < 256; i++) begin
      wait_st(STB_NEED, 1'b1);
      wr(REG_DATA, 32'(i) ^ 32'h3C);
    end
    wait_st(STB_BUSY, 1'b0);
    rbyte(13'h0300, 8'h3C);
    rbyte(13'h03FF, 8'hC3);
    rbyte(13'h02FF, 8'hFF);
    wr(REG_INSTR, 32'h3003_0000);
    for (int i = 0; i < 3; i++) begin
      wait_st(STB_RXFULL, 1'b1);
      rd(REG_DATA);
      check("page byte", 32'(i) ^ 32'h3C, rd_v);
    end
    wr(REG_CONTROL, 32'h0);
    rd(REG_STATUS);
    check("status after abort", 32'h0, rd_v);
    $display("test page done");
  endtask
  // Lock levels in order, skip refused, read back
  task automatic t_lock();
    wr(REG_CONTROL, 32'h1);
    wait_st(STB_BUSY, 1'b0);
    instr(32'hAC53_0000);
    rd(REG_DATA);
    wr(REG_INSTR, 32'hACE2_0000);
    rd(REG_STATUS);
    check("skipped level", 32'h12, rd_v);
    wr(REG_STATUS, 32'h10);
    instr(32'hACE1_0000);
    instr(32'hACE2_0000);
    rd(REG_STATUS);
    check("lock level", 32'h2, 32'(rd_v[9:8]));
    instr(32'h2400_0000);
    rd(REG_DATA);
    check("lock bits", 32'h0C, rd_v);
    $display("test lock done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Clock at 20 MHz
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Main sequence
  initial begin
    rst_b = 1'b0;
    bus = '0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    t_session();
    t_enable();
    t_bytes();
    t_page();
    t_lock();
    close_out();
  end
  // Hang guard, some margin over the expected run of about 84k cycles
  initial begin
    #4_900_000;
    num_errors++;
    close_out();
  end
endmodule // isp_host_tb
